// [logic/qpc_pkg.sv]
package qpc_pkg;

    localparam int unsigned COUNT_W        = 16;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned FILTER_SAMPLES = 3;
    localparam int unsigned SYNC_STAGES    = 2;
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned MAX_LATENCY    = 7;

    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] LATCH_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam int unsigned LOW_BYTE_LSB   = 0;
    localparam int unsigned HIGH_BYTE_LSB  = 8;

    typedef struct packed {
        logic a;
        logic b;
    } quad_t;

    typedef struct packed {
        logic read_enable_n;
        logic byte_select;
    } bus_ctl_t;

    typedef enum logic [1:0] {
        INH_IDLE    = 2'h0,
        INH_HOLD    = 2'h1,
        INH_RELEASE = 2'h3
    } inhibit_state_t;

endpackage : qpc_pkg

// [logic/phase_filter.sv]
`timescale 1ns/10ps
module phase_filter #(
    parameter int unsigned SAMPLES = qpc_pkg::FILTER_SAMPLES
) (
    input  wire logic i_ref_clk,
    input  wire logic i_reset_n,
    input  wire logic i_raw,
    output logic      o_level
);

    logic               sync1_reg;
    logic               sync1_next;
    logic               sync2_reg;
    logic               sync2_next;
    logic [SAMPLES-1:0] hist_reg;
    logic [SAMPLES-1:0] hist_next;
    logic               level_reg;
    logic               level_next;

    if (SAMPLES < 2) begin : g_bad_samples
        $error("phase_filter: SAMPLES must be at least 2");
    end

    always_comb begin
        sync1_next = i_raw;
        sync2_next = sync1_reg;
        hist_next  = {hist_reg[SAMPLES-2:0], sync2_reg};
        level_next = level_reg;
        // level moves only once every stored sample agrees
        if (&hist_reg) begin
            level_next = 1'b1;
        end else if (~|hist_reg) begin
            level_next = 1'b0;
        end
        if (!i_reset_n) begin
            sync1_next = 1'b0;
            sync2_next = 1'b0;
            hist_next  = '0;
            level_next = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        sync1_reg <= sync1_next;
        sync2_reg <= sync2_next;
        hist_reg  <= hist_next;
        level_reg <= level_next;
    end

    assign o_level = level_reg;

    property p_filter_qual;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $changed(level_reg) |-> $past(hist_reg) == {SAMPLES{level_reg}};
    endproperty
    a_filter_qual: assert property (p_filter_qual)
        else $error("filtered level changed without stable samples");

endmodule : phase_filter

// [logic/read_inhibit.sv]
`timescale 1ns/10ps
module read_inhibit (
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_counter_clear_n,
    input  wire qpc_pkg::bus_ctl_t i_bus,
    output logic                  o_inhibit,
    output logic                  o_release_armed
);

    qpc_pkg::inhibit_state_t state_reg;
    qpc_pkg::inhibit_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            qpc_pkg::INH_IDLE: begin
                // select held high means byte mode: no inhibit at all
                if (!i_bus.read_enable_n && !i_bus.byte_select) begin
                    state_next = qpc_pkg::INH_HOLD;
                end
            end
            qpc_pkg::INH_HOLD: begin
                if (!i_bus.read_enable_n && i_bus.byte_select) begin
                    state_next = qpc_pkg::INH_RELEASE;
                end
            end
            qpc_pkg::INH_RELEASE: begin
                if (i_bus.read_enable_n) begin
                    state_next = qpc_pkg::INH_IDLE;
                end else if (!i_bus.byte_select) begin
                    state_next = qpc_pkg::INH_HOLD;
                end
            end
            default: state_next = qpc_pkg::INH_IDLE;
        endcase
        if (!i_reset_n) begin
            state_next = qpc_pkg::INH_IDLE;
        end
    end

    // sampled on the falling edge so host strobes settle after the rise
    always_ff @(negedge i_ref_clk or negedge i_counter_clear_n) begin
        if (!i_counter_clear_n) begin
            state_reg <= qpc_pkg::INH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_inhibit       = (state_reg != qpc_pkg::INH_IDLE);
    assign o_release_armed = (state_reg == qpc_pkg::INH_RELEASE);

    property p_inh_set;
        @(negedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (!i_bus.read_enable_n && !i_bus.byte_select) |=> o_inhibit;
    endproperty
    a_inh_set: assert property (p_inh_set)
        else $error("inhibit not set by high byte read");

    property p_inh_arm;
        @(negedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (o_inhibit && !i_bus.read_enable_n && i_bus.byte_select)
            |=> o_inhibit && o_release_armed;
    endproperty
    a_inh_arm: assert property (p_inh_arm)
        else $error("low byte read did not arm release");

    property p_inh_release;
        @(negedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (o_release_armed && i_bus.read_enable_n) |=> !o_inhibit;
    endproperty
    a_inh_release: assert property (p_inh_release)
        else $error("inhibit not released after read");

endmodule : read_inhibit

// [logic/quadrature_position_counter_readout.sv]
`timescale 1ns/10ps
// Operation
// - qualified input change reaches the counter within eight clocks
// - 16-bit up/down counter updates on rising clock edges, except the asynchronous counter clear
// - one count per valid transition; A leading counts up, B down
// - filtered level changes after three equal consecutive samples
// - counter wraps modulo 65536, never saturates
// - counter clear input resets the position counter to zero
// - latch loads counter every rising edge unless inhibited
// - counter clear zeroes the latch asynchronously
// - inhibit samples enable and select on falling edges only
// - counter clear forces inhibit inactive asynchronously
// - select and enable low at falling edge set inhibit, high byte
// - select high, enable low: low byte, release armed, inhibit held
// - enable high after arming drops inhibit at falling edge
// - 16-to-8 mux drives latch bytes onto three-state bus
// - enable low: select low high byte, select high low byte
// - half-cycle decoded-count pulse in the counter update cycle
// - direction valid a cycle before pulse rise; inhibit-independent
// - half-cycle carry/borrow pulse on overflow or underflow
module quadrature_position_counter_readout (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_counter_clear_n,
    input  wire logic                  i_encoder_phase_a,
    input  wire logic                  i_encoder_phase_b,
    input  wire logic                  i_read_enable_n,
    input  wire logic                  i_byte_select,
    output logic [qpc_pkg::BYTE_W-1:0] o_bus_data,
    output logic                       o_bus_data_oe,
    output logic                       o_decoded_count_pulse,
    output logic                       o_carry_borrow_pulse,
    output logic                       o_up_down
);

    localparam int unsigned CW = qpc_pkg::COUNT_W;
    localparam int unsigned BW = qpc_pkg::BYTE_W;

    qpc_pkg::quad_t    filt;
    qpc_pkg::bus_ctl_t bus_ctl;
    logic              inhibit;
    logic              release_armed;

    // decoder stage
    qpc_pkg::quad_t    prev_reg;
    qpc_pkg::quad_t    prev_next;
    logic              cnt_pend_reg;
    logic              cnt_pend_next;
    logic              dir_reg;
    logic              dir_next;
    logic              step;
    logic              up;

    // counter stage, cleared asynchronously
    logic [CW-1:0]     count_reg;
    logic [CW-1:0]     count_next;
    logic [CW-1:0]     latch_reg;
    logic [CW-1:0]     latch_next;
    logic              dec_tgl_reg;
    logic              dec_tgl_next;
    logic              cas_tgl_reg;
    logic              cas_tgl_next;
    logic              wrap;

    // falling-edge followers that end each pulse half a cycle later
    logic              dec_fall_reg;
    logic              dec_fall_next;
    logic              cas_fall_reg;
    logic              cas_fall_next;

    phase_filter #(
        .SAMPLES (qpc_pkg::FILTER_SAMPLES)
    ) u_filter_a (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_raw     (i_encoder_phase_a),
        .o_level   (filt.a)
    );

    phase_filter #(
        .SAMPLES (qpc_pkg::FILTER_SAMPLES)
    ) u_filter_b (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_raw     (i_encoder_phase_b),
        .o_level   (filt.b)
    );

    // host strobes are on this clock already, so no synchroniser
    assign bus_ctl.read_enable_n = i_read_enable_n;
    assign bus_ctl.byte_select   = i_byte_select;

    read_inhibit u_inhibit (
        .i_ref_clk         (i_ref_clk),
        .i_reset_n         (i_reset_n),
        .i_counter_clear_n (i_counter_clear_n),
        .i_bus             (bus_ctl),
        .o_inhibit         (inhibit),
        .o_release_armed   (release_armed)
    );

    always_comb begin
        step = (filt.a ^ prev_reg.a) ^ (filt.b ^ prev_reg.b);
        // a leading b gives 00-10-11-01, where old a equals new b
        up            = ~(prev_reg.a ^ filt.b);
        prev_next     = filt;
        cnt_pend_next = step;
        dir_next      = step ? up : dir_reg;
        if (!i_reset_n) begin
            prev_next     = '0;
            cnt_pend_next = 1'b0;
            dir_next      = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        prev_reg     <= prev_next;
        cnt_pend_reg <= cnt_pend_next;
        dir_reg      <= dir_next;
    end

    always_comb begin
        count_next = count_reg;
        wrap = cnt_pend_reg && (dir_reg ? (count_reg == qpc_pkg::COUNT_MAX)
                                        : (count_reg == qpc_pkg::COUNT_RESET));
        if (cnt_pend_reg) begin
            // plain 16-bit add and subtract wrap on their own
            count_next = dir_reg ? count_reg + 16'h0001
                                 : count_reg - 16'h0001;
        end
        latch_next   = inhibit ? latch_reg : count_reg;
        dec_tgl_next = dec_tgl_reg ^ cnt_pend_reg;
        cas_tgl_next = cas_tgl_reg ^ wrap;
        if (!i_reset_n) begin
            count_next   = qpc_pkg::COUNT_RESET;
            latch_next   = qpc_pkg::LATCH_RESET;
            dec_tgl_next = 1'b0;
            cas_tgl_next = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_counter_clear_n) begin
        if (!i_counter_clear_n) begin
            count_reg   <= qpc_pkg::COUNT_RESET;
            latch_reg   <= qpc_pkg::LATCH_RESET;
            dec_tgl_reg <= 1'b0;
            cas_tgl_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            latch_reg   <= latch_next;
            dec_tgl_reg <= dec_tgl_next;
            cas_tgl_reg <= cas_tgl_next;
        end
    end

    always_comb begin
        dec_fall_next = dec_tgl_reg;
        cas_fall_next = cas_tgl_reg;
        if (!i_reset_n) begin
            dec_fall_next = 1'b0;
            cas_fall_next = 1'b0;
        end
    end

    always_ff @(negedge i_ref_clk or negedge i_counter_clear_n) begin
        if (!i_counter_clear_n) begin
            dec_fall_reg <= 1'b0;
            cas_fall_reg <= 1'b0;
        end else begin
            dec_fall_reg <= dec_fall_next;
            cas_fall_reg <= cas_fall_next;
        end
    end

    // toggle pairs: only one flop moves per edge, so the xor is clean
    assign o_decoded_count_pulse = dec_tgl_reg ^ dec_fall_reg;
    assign o_carry_borrow_pulse  = cas_tgl_reg ^ cas_fall_reg;
    assign o_up_down             = dir_reg;

    // the bus follows the strobes without a clock, as a plain mux would
    assign o_bus_data_oe = ~i_read_enable_n;
    assign o_bus_data    = i_byte_select
                         ? latch_reg[qpc_pkg::LOW_BYTE_LSB +: BW]
                         : latch_reg[qpc_pkg::HIGH_BYTE_LSB +: BW];

    property p_latency;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (filt != $past(filt)) && (^(filt ^ $past(filt)))
            |=> cnt_pend_reg ##1 (count_reg != $past(count_reg));
    endproperty
    a_latency: assert property (p_latency)
        else $error("qualified change did not reach the counter in time");

    property p_count_hold;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        !cnt_pend_reg |=> $stable(count_reg);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("counter moved without a decoded count");

    property p_count_up;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (cnt_pend_reg && dir_reg)
            |=> count_reg == CW'($past(count_reg) + 16'h0001);
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("up count did not increment by one");

    property p_count_down;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (cnt_pend_reg && !dir_reg)
            |=> count_reg == CW'($past(count_reg) - 16'h0001);
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("down count did not decrement by one");

    property p_wrap;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (cnt_pend_reg && dir_reg && count_reg == qpc_pkg::COUNT_MAX)
            |=> count_reg == qpc_pkg::COUNT_RESET
                && cas_tgl_reg != $past(cas_tgl_reg);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("overflow did not wrap with a cascade pulse");

    property p_wrap_down;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        (cnt_pend_reg && !dir_reg && count_reg == qpc_pkg::COUNT_RESET)
            |=> count_reg == qpc_pkg::COUNT_MAX
                && cas_tgl_reg != $past(cas_tgl_reg);
    endproperty
    a_wrap_down: assert property (p_wrap_down)
        else $error("underflow did not wrap with a cascade pulse");

    // a range end passed without a count must leave the cascade quiet
    property p_cas_only_wrap;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        !(cnt_pend_reg && (count_reg == qpc_pkg::COUNT_MAX
                           || count_reg == qpc_pkg::COUNT_RESET))
            |=> $stable(cas_tgl_reg);
    endproperty
    a_cas_only_wrap: assert property (p_cas_only_wrap)
        else $error("cascade pulse without overflow or underflow");

    property p_clear;
        @(posedge i_ref_clk)
        !i_counter_clear_n |-> count_reg == qpc_pkg::COUNT_RESET
                            && latch_reg == qpc_pkg::LATCH_RESET
                            && !inhibit;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter clear did not zero counter, latch, inhibit");

    property p_latch_load;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        !inhibit |=> latch_reg == $past(count_reg);
    endproperty
    a_latch_load: assert property (p_latch_load)
        else $error("latch failed to capture the counter");

    property p_latch_hold;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        inhibit |=> $stable(latch_reg);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch changed while inhibited");

    property p_bus_mux;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !i_read_enable_n |-> o_bus_data_oe
            && o_bus_data == (i_byte_select ? latch_reg[7:0]
                                            : latch_reg[15:8]);
    endproperty
    a_bus_mux: assert property (p_bus_mux)
        else $error("bus byte does not match select");

    property p_pulse_dir;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        cnt_pend_reg |=> dec_tgl_reg != $past(dec_tgl_reg)
                      && !o_decoded_count_pulse
                      && (o_up_down == $past(o_up_down) || cnt_pend_reg);
    endproperty
    a_pulse_dir: assert property (p_pulse_dir)
        else $error("count pulse or direction wrong around update");

    property p_pulse_ends;
        @(posedge i_ref_clk) disable iff (!i_reset_n || !i_counter_clear_n)
        1'b1 |-> !o_decoded_count_pulse && !o_carry_borrow_pulse;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends)
        else $error("output pulse lasted past the falling edge");

    c_up_count: cover property (@(posedge i_ref_clk)
        cnt_pend_reg && dir_reg);
    c_down_count: cover property (@(posedge i_ref_clk)
        cnt_pend_reg && !dir_reg);
    c_wrap_down: cover property (@(posedge i_ref_clk) wrap && !dir_reg);
    c_wrap_up: cover property (@(posedge i_ref_clk) wrap && dir_reg);
    c_two_byte_read: cover property (@(posedge i_ref_clk)
        release_armed ##[1:20] !inhibit);

endmodule : quadrature_position_counter_readout

// [tb/host_encoder_model.sv]
`timescale 1ns/10ps
module host_encoder_model (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_bus,
    output logic            o_phase_a,
    output logic            o_phase_b,
    output logic            o_read_enable_n,
    output logic            o_byte_select
);
    logic [1:0] state_idx;

    initial begin
        o_phase_a       = 1'b0;
        o_phase_b       = 1'b0;
        o_read_enable_n = 1'b1;
        o_byte_select   = 1'b1;
        state_idx       = 2'h0;
    end

    // gray walk 00,10,11,01 has phase a leading when moving up;
    // the caller spaces steps by ten cycles or more
    task automatic step(input logic up);
        state_idx = up ? state_idx + 2'h1 : state_idx - 2'h1;
        @(posedge i_ref_clk);
        o_phase_a <= state_idx[0] ^ state_idx[1];
        o_phase_b <= state_idx[1];
    endtask : step

    // a two-cycle spike that a compliant encoder never makes
    task automatic glitch;
        @(posedge i_ref_clk);
        o_phase_a <= ~o_phase_a;
        repeat (2) @(posedge i_ref_clk);
        o_phase_a <= ~o_phase_a;
    endtask : glitch

    // strobes change only just after a rising edge
    task automatic set_strobes(input logic oe_n, input logic sel);
        @(posedge i_ref_clk);
        o_read_enable_n <= oe_n;
        o_byte_select   <= sel;
    endtask : set_strobes

    task automatic read_high(output logic [7:0] hi);
        set_strobes(1'b0, 1'b0);
        @(negedge i_ref_clk);
        #2;
        hi = i_bus;
    endtask : read_high

    task automatic read_low_release(output logic [7:0] lo);
        set_strobes(1'b0, 1'b1);
        @(negedge i_ref_clk);
        #2;
        lo = i_bus;
        set_strobes(1'b1, 1'b1);
        @(negedge i_ref_clk);
    endtask : read_low_release
endmodule : host_encoder_model

// [tb/test_quadrature_position_counter_readout.sv]
`timescale 1ns/10ps
module test_quadrature_position_counter_readout;
    logic        ref_clk   = 1'b0;
    logic        reset_n   = 1'b0;
    logic        clear_n   = 1'b1;
    logic        phase_a;
    logic        phase_b;
    logic        read_en_n;
    logic        byte_sel;
    logic [7:0]  bus_data;
    logic        bus_oe;
    logic        dec_pulse;
    logic        cas_pulse;
    logic        up_down;
    logic [7:0]  last_bus  = 8'h00;
    logic [7:0]  bus_wire;
    logic [15:0] exp_pos   = 16'h0000;
    logic        exp_dir   = 1'b0;
    logic        dir_prev  = 1'b0;
    int          n_dec     = 0;
    int          n_cas     = 0;
    int          exp_cas   = 0;
    int          n_fail    = 0;
    int          checks    = 0;

    always #12.5 ref_clk = ~ref_clk;

    quadrature_position_counter_readout quadrature_position_counter_readout_i (
        .i_ref_clk             (ref_clk),
        .i_reset_n             (reset_n),
        .i_counter_clear_n     (clear_n),
        .i_encoder_phase_a     (phase_a),
        .i_encoder_phase_b     (phase_b),
        .i_read_enable_n       (read_en_n),
        .i_byte_select         (byte_sel),
        .o_bus_data            (bus_data),
        .o_bus_data_oe         (bus_oe),
        .o_decoded_count_pulse (dec_pulse),
        .o_carry_borrow_pulse  (cas_pulse),
        .o_up_down             (up_down)
    );

    host_encoder_model host_encoder_model_i (
        .i_ref_clk       (ref_clk),
        .i_bus           (bus_wire),
        .o_phase_a       (phase_a),
        .o_phase_b       (phase_b),
        .o_read_enable_n (read_en_n),
        .o_byte_select   (byte_sel)
    );

    // a released bus has no pull: show a value the host must not trust
    always @(ref_clk) if (bus_oe === 1'b1) last_bus <= bus_data;
    assign bus_wire = (bus_oe === 1'b1) ? bus_data : ~last_bus;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // pulses are judged mid high phase and again after the falling edge
    always @(posedge ref_clk) begin
        #5;
        if (dec_pulse === 1'b1) begin
            n_dec++;
            check({15'h0, up_down}, {15'h0, exp_dir});
            check({15'h0, up_down}, {15'h0, dir_prev});
        end
        if (cas_pulse === 1'b1) n_cas++;
        dir_prev = up_down;
        if (dec_pulse === 1'b1 || cas_pulse === 1'b1) begin
            @(negedge ref_clk);
            #2;
            check({14'h0, dec_pulse, cas_pulse}, 16'h0000);
        end
    end

    task automatic mv(input logic up, input int n);
        int k;
        int n0;
        for (int s = 0; s < n; s++) begin
            n0 = n_dec;
            exp_dir = up;
            host_encoder_model_i.step(up);
            k = 0;
            while (n_dec == n0 && k < 12) begin
                @(posedge ref_clk);
                #10;
                k++;
            end
            check({15'h0, n_dec == n0 + 1 && k <= 8}, 16'h0001);
            if (n_dec == n0) summarize();
            if ((up && exp_pos == 16'hFFFF) || (!up && exp_pos == 16'h0))
                exp_cas++;
            exp_pos = up ? exp_pos + 16'h1 : exp_pos - 16'h1;
            repeat (2) @(posedge ref_clk);
        end
    endtask : mv

    task automatic read_word(output logic [15:0] w);
        host_encoder_model_i.read_high(w[15:8]);
        host_encoder_model_i.read_low_release(w[7:0]);
    endtask : read_word

    task automatic t_reset;
        logic [15:0] w;
        check({14'h0, dec_pulse, cas_pulse}, 16'h0000);
        check({15'h0, up_down}, 16'h0000);
        read_word(w);
        check(w, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    // up, down through zero and back up through the top
    task automatic t_count;
        logic [15:0] w;
        mv(1'b1, 3);
        read_word(w);
        check(w, exp_pos);
        mv(1'b0, 4);
        read_word(w);
        check(w, 16'hFFFF);
        mv(1'b1, 1);
        read_word(w);
        check(w, 16'h0000);
        check(n_cas[15:0], exp_cas[15:0]);
        $display("test count done");
    endtask : t_count

    task automatic t_glitch;
        int n0;
        n0 = n_dec;
        host_encoder_model_i.glitch();
        repeat (12) @(posedge ref_clk);
        check(n_dec[15:0], n0[15:0]);
        $display("test glitch done");
    endtask : t_glitch

    // counts during a two-byte read must not tear the word
    task automatic t_inhibit;
        logic [7:0]  h;
        logic [7:0]  l;
        logic [15:0] w;
        mv(1'b0, 1);
        host_encoder_model_i.read_high(h);
        check({8'h0, h}, 16'h00FF);
        mv(1'b1, 2);
        host_encoder_model_i.read_low_release(l);
        check({8'h0, l}, 16'h00FF);
        check({15'h0, bus_oe}, 16'h0000);
        read_word(w);
        check(w, exp_pos);
        check(n_cas[15:0], exp_cas[15:0]);
        $display("test inhibit done");
    endtask : t_inhibit

    // enable raised before the low byte leaves the latch frozen
    task automatic t_hold;
        logic [7:0]  h;
        logic [7:0]  l;
        logic [15:0] w;
        host_encoder_model_i.read_high(h);
        host_encoder_model_i.set_strobes(1'b1, 1'b0);
        mv(1'b1, 1);
        host_encoder_model_i.read_high(h);
        host_encoder_model_i.read_low_release(l);
        check({h, l}, exp_pos - 16'h1);
        read_word(w);
        check(w, exp_pos);
        $display("test hold done");
    endtask : t_hold

    task automatic t_clear;
        logic [7:0]  h;
        logic [15:0] w;
        mv(1'b0, 3);
        host_encoder_model_i.read_high(h);
        check({8'h0, h}, 16'h00FF);
        @(posedge ref_clk);
        clear_n <= 1'b0;
        #3;
        check({8'h0, bus_wire}, 16'h0000);
        host_encoder_model_i.set_strobes(1'b0, 1'b1);
        @(posedge ref_clk);
        clear_n <= 1'b1;
        exp_pos = 16'h0000;
        mv(1'b1, 2);
        check({8'h0, bus_wire}, 16'h0002);
        host_encoder_model_i.set_strobes(1'b1, 1'b1);
        read_word(w);
        check(w, 16'h0002);
        $display("test clear done");
    endtask : t_clear

    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        $display("[ERR] t=%0t run did not finish", $time);
        summarize();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_count();
        t_glitch();
        t_inhibit();
        t_hold();
        t_clear();
        summarize();
    end
endmodule : test_quadrature_position_counter_readout
